// *** pkg/fspc_pkg.sv ***
/*
  Package for the flash self-programming controller: register offsets, field
  positions, reset values, command codes, states and operation timings.
  Assumes a 10 MHz CPU clock (core_clk_i) and a byte-wide internal register bus.
*/
package fspc_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 10_000_000;

  // Register offsets on the internal bus
  localparam logic [7:0] UNLOCK_CMD_OFS   = 8'hA0;
  localparam logic [7:0] ERR_STATUS_OFS   = 8'hA1;
  localparam logic [7:0] MODE_CTRL_OFS    = 8'hA2;
  localparam logic [7:0] PROG_CMD_OFS     = 8'hA3;
  localparam logic [7:0] ADDR_PTR_HI_OFS  = 8'hA4;
  localparam logic [7:0] ADDR_PTR_LO_OFS  = 8'hA5;
  localparam logic [7:0] ADDR_CMP_HI_OFS  = 8'hA6;
  localparam logic [7:0] ADDR_CMP_LO_OFS  = 8'hA7;
  localparam logic [7:0] WRITE_BUF_OFS    = 8'hA8;

  // Unlock key and protect byte location
  localparam logic [7:0]  UNLOCK_KEY       = 8'hA5;
  localparam logic [15:0] PROTECT_BYTE_ADR = 16'h0081;

  // Field positions
  localparam int unsigned MODE_SEL_BIT     = 0;
  localparam int unsigned PROT_LSB         = 2;
  localparam int unsigned PROT_MSB         = 6;
  localparam int unsigned ERR_UNLOCK_BIT   = 0;
  localparam int unsigned ERR_VERIFY_BIT   = 1;
  localparam int unsigned ERR_PROTECT_BIT  = 2;

  // Reset values
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [7:0] BLANK_BYTE   = 8'hFF;
  localparam logic [4:0] PROT_RST     = 5'h1F;

  // Command codes
  typedef enum logic [2:0] {
    FSPC_CMD_NONE    = 3'h0,
    FSPC_CMD_VERIFY1 = 3'h1,
    FSPC_CMD_VERIFY2 = 3'h2,
    FSPC_CMD_ERASE   = 3'h3,
    FSPC_CMD_BLANK   = 3'h4,
    FSPC_CMD_WRITE   = 3'h5
  } fspc_cmd_t;

  // Sequencer states, Gray along idle -> busy -> done
  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_BUSY = 2'b01,
    FSPC_DONE = 2'b11
  } fspc_state_t;

  // Unlock sequence steps
  typedef enum logic [1:0] {
    FSPC_UL_IDLE  = 2'b00,
    FSPC_UL_KEYED = 2'b01,
    FSPC_UL_VAL   = 2'b11,
    FSPC_UL_INV   = 2'b10
  } fspc_ul_t;

  // Operation times in ns, cycle counts derived from them
  localparam longint unsigned T_VERIFY1_NS   = 64'd6_800_000;
  localparam longint unsigned T_VERIFY2_NS   = 64'd27_000;
  localparam longint unsigned T_ERASE_NS     = 64'd8_500_000;
  localparam longint unsigned T_BLANK_NS     = 64'd480_000;
  localparam longint unsigned T_WRITE_NS     = 64'd150_000;
  localparam longint unsigned T_ENTRY_NS     = 64'd10_000;
  localparam longint unsigned ENTRY_EXTRA    = 64'd2;
  localparam longint unsigned NS_PER_S       = 64'd1_000_000_000;

  localparam int unsigned CYC_VERIFY1 = int'(T_VERIFY1_NS * CLK_HZ / NS_PER_S);
  localparam int unsigned CYC_VERIFY2 = int'(T_VERIFY2_NS * CLK_HZ / NS_PER_S);
  localparam int unsigned CYC_ERASE   = int'(T_ERASE_NS * CLK_HZ / NS_PER_S);
  localparam int unsigned CYC_BLANK   = int'(T_BLANK_NS * CLK_HZ / NS_PER_S);
  localparam int unsigned CYC_WRITE   = int'(T_WRITE_NS * CLK_HZ / NS_PER_S);
  localparam int unsigned CYC_ENTRY   = int'(T_ENTRY_NS * CLK_HZ / NS_PER_S + ENTRY_EXTRA);

  localparam int unsigned CNT_W = 17;

endpackage

// *** pkg/fspc_flash_if.sv ***
/*
  Interface between the controller and its flash array port.
  Assumes both ends run on core_clk_i.
*/
`timescale 1ns/1ps
interface fspc_flash_if;
  logic        rd_en;
  logic        wr_en;
  logic        erase_en;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport ctrl (
    output rd_en,
    output wr_en,
    output erase_en,
    output addr,
    output wdata,
    input  rdata
  );

  modport mem (
    input  rd_en,
    input  wr_en,
    input  erase_en,
    input  addr,
    input  wdata,
    output rdata
  );
endinterface

// *** hw/fspc_timer.sv ***
/*
  Down-counter that times one flash operation.
  Assumes load and tick arrive from logic on core_clk_i.
*/
`timescale 1ns/1ps
module fspc_timer
  import fspc_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] count_i,
  // Status
  output logic                  expired_o
);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (clk_en_i) begin
      if (load_i) begin
        cnt_q <= count_i;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign expired_o = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule // fspc_timer

// *** hw/fspc_ctrl.sv ***
/*
  Flash self-programming controller: protected mode register, command, address
  and write-buffer registers, error status, and a sequencer that runs one flash
  operation while the CPU is held in HALT.
  Assumes a byte-wide register bus from the CPU on core_clk_i, a halt request
  pulse from the CPU core, and a flash array reached through fspc_flash_if.
*/
// What this block does
// - In self mode, HALT starts the set command; HALT released when it ends
// - Maskable interrupt servicing blocked while self mode is active
// - Whole-block verify reads a block but never flags an error, done within 6.8 ms of HALT
// - Multi-address verify checks bytes in a block, 27 us per byte
// - Software sets block number first; block erase takes 8.5 ms
// - Blank check tells whether the block is erased, taking 480 us
// - Byte write programs the buffer byte at the address in 150 us
// - CPU runs no instruction while a command executes; software restarts watchdog
// - Interrupts raised in self mode stay pending until the mode is left
// - A running command makes no data RAM access
// - After block erase every byte of the block reads FFH
// - Mode-entry HALT released within 10 us plus 2 CPU clocks
// - External security is ignored; only the protect byte blocks writes
// - Protect byte sits at flash address 0081H
// - Mode register accepts only the write that completes the unlock sequence
// - Mode bit 0 means HALT is standby; 1 means HALT runs command
// - Mode bit clears at reset; bits 2 to 6 load protect byte, read-only
// - Broken unlock leaves mode unchanged and sets error; write 0 clears
// - Verify fails set bit 1; protect or bad write set bit 2; write 0 clears
`timescale 1ns/1ps
module fspc_ctrl
  import fspc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // Register bus
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // CPU control
  input  wire logic        halt_req_i,
  output logic             halt_o,
  output logic             irq_block_o,
  output logic             ram_block_o,
  // Flash array
  output logic             fl_rd_en_o,
  output logic             fl_wr_en_o,
  output logic             fl_erase_en_o,
  output logic [15:0]      fl_addr_o,
  output logic [7:0]       fl_wdata_o,
  input  wire logic [7:0]  fl_rdata_i
);

  fspc_flash_if fl ();

  // Registers
  logic              mode_q;
  logic [4:0]        prot_q;
  logic              prot_load_q;
  logic [2:0]        err_q;
  logic [2:0]        cmd_q;
  logic [7:0]        ptr_hi_q;
  logic [7:0]        ptr_lo_q;
  logic [7:0]        cmp_hi_q;
  logic [7:0]        cmp_lo_q;
  logic [7:0]        wbuf_q;
  fspc_ul_t          ul_q;
  logic              ul_val_q;
  fspc_state_t       st_q;
  fspc_state_t       st_d;
  logic              entry_q;
  logic [7:0]        rdata_q;
  logic [7:0]        scan_q;
  logic              fail_q;

  // Bus decode
  wire wr_ucmd  = reg_wr_i && (reg_addr_i == UNLOCK_CMD_OFS);
  wire wr_err   = reg_wr_i && (reg_addr_i == ERR_STATUS_OFS);
  wire wr_mode  = reg_wr_i && (reg_addr_i == MODE_CTRL_OFS);
  wire wr_cmd   = reg_wr_i && (reg_addr_i == PROG_CMD_OFS);
  wire wr_phi   = reg_wr_i && (reg_addr_i == ADDR_PTR_HI_OFS);
  wire wr_plo   = reg_wr_i && (reg_addr_i == ADDR_PTR_LO_OFS);
  wire wr_chi   = reg_wr_i && (reg_addr_i == ADDR_CMP_HI_OFS);
  wire wr_clo   = reg_wr_i && (reg_addr_i == ADDR_CMP_LO_OFS);
  wire wr_wbuf  = reg_wr_i && (reg_addr_i == WRITE_BUF_OFS);
  wire mode_bit = reg_wdata_i[MODE_SEL_BIT];

  wire ul_keyed_ok = (ul_q == FSPC_UL_KEYED) && wr_mode;
  wire ul_inv_ok   = (ul_q == FSPC_UL_VAL) && wr_mode && (mode_bit == !ul_val_q);
  wire ul_commit   = (ul_q == FSPC_UL_INV) && wr_mode && (mode_bit == ul_val_q);
  wire ul_break    = reg_wr_i && !wr_ucmd && !ul_keyed_ok && !ul_inv_ok && !ul_commit
                     && ((ul_q != FSPC_UL_IDLE) || wr_mode);
  wire ul_key_bad  = wr_ucmd && (reg_wdata_i != UNLOCK_KEY);

  // Sequencer decode
  fspc_cmd_t cmd_e;
  assign cmd_e = fspc_cmd_t'(cmd_q);
  wire [15:0] ptr      = {ptr_hi_q, ptr_lo_q};
  wire [15:0] cmp      = {cmp_hi_q, cmp_lo_q};
  // only protect byte gates; bit n protects block group n of pointer-high
  wire        prot_hit = prot_q[ptr_hi_q[4:2]] == 1'b0 && ptr_hi_q[4:2] < 3'd5;
  wire        modifies = (cmd_e == FSPC_CMD_ERASE) || (cmd_e == FSPC_CMD_WRITE);
  wire        cmd_ok   = (cmd_e != FSPC_CMD_NONE) && (cmd_q <= 3'd5);
  // HALT starts command only in self mode
  wire        start    = halt_req_i && mode_q && (st_q == FSPC_IDLE) && !entry_q && cmd_ok;

  logic [CNT_W-1:0] load_cnt;
  always_comb begin
    case (cmd_e)
      FSPC_CMD_VERIFY1: load_cnt = CNT_W'(CYC_VERIFY1);
      FSPC_CMD_VERIFY2: load_cnt = CNT_W'(CYC_VERIFY2);
      FSPC_CMD_ERASE:   load_cnt = CNT_W'(CYC_ERASE);
      FSPC_CMD_BLANK:   load_cnt = CNT_W'(CYC_BLANK);
      FSPC_CMD_WRITE:   load_cnt = CNT_W'(CYC_WRITE);
      default:          load_cnt = CNT_W'(1);
    endcase
  end

  logic tmr_expired;
  // Only a running multi-address verify may step on; the entry timer shares the expiry strobe
  wire  v2_next   = (st_q == FSPC_BUSY) && (cmd_e == FSPC_CMD_VERIFY2) && tmr_expired && (ptr != cmp);
  wire  entry_go  = ul_commit && mode_bit && !mode_q;
  wire  tmr_load  = start || v2_next || entry_go;

  fspc_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .load_i     (tmr_load),
    .count_i    (entry_go ? CNT_W'(CYC_ENTRY) : load_cnt),
    .expired_o  (tmr_expired)
  );

  wire op_end = (st_q == FSPC_BUSY) && tmr_expired
                && ((cmd_e != FSPC_CMD_VERIFY2) || (ptr == cmp));

  always_comb begin
    case (st_q)
      FSPC_IDLE: st_d = start ? FSPC_BUSY : FSPC_IDLE;
      FSPC_BUSY: st_d = op_end ? FSPC_DONE : FSPC_BUSY;
      FSPC_DONE: st_d = FSPC_IDLE;
      default:   st_d = FSPC_IDLE;
    endcase
  end

  // Flash port: block reads scan the pointer's block; multi-address verify and write use the pointer
  wire busy      = (st_q == FSPC_BUSY);
  wire is_verify = (cmd_e == FSPC_CMD_VERIFY1) || (cmd_e == FSPC_CMD_VERIFY2)
                   || (cmd_e == FSPC_CMD_BLANK);
  wire [15:0] blk_addr = {ptr_hi_q, scan_q};
  // writes read the old byte, else the unerased-bit check sees no real data
  assign fl.rd_en    = busy && (is_verify || (cmd_e == FSPC_CMD_WRITE));
  // byte write at end of timing
  assign fl.wr_en    = op_end && (cmd_e == FSPC_CMD_WRITE) && !prot_hit;
  // erase fills block with blank bytes
  assign fl.erase_en = op_end && (cmd_e == FSPC_CMD_ERASE) && !prot_hit;
  assign fl.addr     = (cmd_e == FSPC_CMD_VERIFY2 || cmd_e == FSPC_CMD_WRITE) ? ptr : blk_addr;
  assign fl.wdata    = wbuf_q;
  assign fl.rdata    = fl_rdata_i;
  // blank check compares with erased value
  wire rd_bad = fl.rd_en && ((cmd_e == FSPC_CMD_BLANK) ? (fl.rdata != BLANK_BYTE)
                : (cmd_e == FSPC_CMD_VERIFY2) ? (fl.rdata != wbuf_q) : 1'b0);
  // protect violation or writing 1 over a 0 bit
  wire prot_err = op_end && modifies && prot_hit;
  wire zero_err = op_end && (cmd_e == FSPC_CMD_WRITE) && ((~fl.rdata & wbuf_q) != 8'h00);
  wire vfy_err  = op_end && (fail_q || rd_bad);

  // Mode, protect setting, unlock tracker
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q      <= 1'b0;
      prot_q      <= PROT_RST;
      prot_load_q <= 1'b1;
      ul_q        <= FSPC_UL_IDLE;
      ul_val_q    <= 1'b0;
    end else if (clk_en_i) begin
      // protect byte loaded after reset release
      if (prot_load_q) begin
        prot_q      <= fl.rdata[4:0];
        prot_load_q <= 1'b0;
      end
      if (wr_ucmd) begin
        ul_q <= (reg_wdata_i == UNLOCK_KEY) ? FSPC_UL_KEYED : FSPC_UL_IDLE;
      end else if (ul_keyed_ok) begin
        ul_q     <= FSPC_UL_VAL;
        ul_val_q <= mode_bit;
      end else if (ul_inv_ok) begin
        ul_q <= FSPC_UL_INV;
      end else if (reg_wr_i) begin
        ul_q <= FSPC_UL_IDLE;
      end
      // mode bit set only by commit
      if (ul_commit) begin
        mode_q <= mode_bit;
      end
    end
  end

  // Program registers and error flags
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q    <= 3'b000;
      cmd_q    <= 3'b000;
      ptr_hi_q <= BYTE_RST;
      ptr_lo_q <= BYTE_RST;
      cmp_hi_q <= BYTE_RST;
      cmp_lo_q <= BYTE_RST;
      wbuf_q   <= BYTE_RST;
    end else if (clk_en_i) begin
      err_q[ERR_UNLOCK_BIT]  <= (ul_break || ul_key_bad) ||
                                (err_q[ERR_UNLOCK_BIT] && !(wr_err && !reg_wdata_i[ERR_UNLOCK_BIT]));
      err_q[ERR_VERIFY_BIT]  <= vfy_err ||
                                (err_q[ERR_VERIFY_BIT] && !(wr_err && !reg_wdata_i[ERR_VERIFY_BIT]));
      err_q[ERR_PROTECT_BIT] <= prot_err || zero_err ||
                                (err_q[ERR_PROTECT_BIT] && !(wr_err && !reg_wdata_i[ERR_PROTECT_BIT]));
      if (wr_cmd) cmd_q <= reg_wdata_i[2:0];
      if (wr_phi) ptr_hi_q <= reg_wdata_i;
      if (wr_chi) cmp_hi_q <= reg_wdata_i;
      if (wr_clo) cmp_lo_q <= reg_wdata_i;
      if (wr_wbuf) wbuf_q <= reg_wdata_i;
      if (wr_plo) begin
        ptr_lo_q <= reg_wdata_i;
      end else if (v2_next && busy) begin
        {ptr_hi_q, ptr_lo_q} <= ptr + 16'h0001;
      end
    end
  end

  // Sequencer, entry HALT, block scan
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q    <= FSPC_IDLE;
      entry_q <= 1'b0;
      scan_q  <= BYTE_RST;
      fail_q  <= 1'b0;
    end else if (clk_en_i) begin
      st_q <= st_d;
      if (entry_go) begin
        entry_q <= 1'b1;
      end else if (tmr_expired) begin
        entry_q <= 1'b0;
      end
      if (start) begin
        scan_q <= BYTE_RST;
        fail_q <= 1'b0;
      end else if (busy) begin
        scan_q <= scan_q + 8'h01;
        if (rd_bad) fail_q <= 1'b1;
      end
    end
  end

  // Register read data
  wire [7:0] mode_rd = {1'b0, prot_q, 1'b0, mode_q};
  always_comb begin
    case (reg_addr_i)
      ERR_STATUS_OFS:  rdata_q = {5'b0, err_q};
      MODE_CTRL_OFS:   rdata_q = mode_rd;
      PROG_CMD_OFS:    rdata_q = {5'b0, cmd_q};
      ADDR_PTR_HI_OFS: rdata_q = ptr_hi_q;
      ADDR_PTR_LO_OFS: rdata_q = ptr_lo_q;
      ADDR_CMP_HI_OFS: rdata_q = cmp_hi_q;
      ADDR_CMP_LO_OFS: rdata_q = cmp_lo_q;
      WRITE_BUF_OFS:   rdata_q = wbuf_q;
      default:         rdata_q = 8'h00;
    endcase
  end
  assign reg_rdata_o = reg_rd_i ? rdata_q : 8'h00;

  // stall CPU while command or entry runs
  assign halt_o        = (st_q == FSPC_BUSY) || start || entry_q;
  // interrupts held pending in self mode
  assign irq_block_o   = mode_q;
  // no data RAM access while busy
  assign ram_block_o   = halt_o;
  assign fl_rd_en_o    = fl.rd_en || prot_load_q;
  assign fl_wr_en_o    = fl.wr_en;
  assign fl_erase_en_o = fl.erase_en;
  assign fl_addr_o     = prot_load_q ? PROTECT_BYTE_ADR : fl.addr;
  assign fl_wdata_o    = fl.wdata;

endmodule // fspc_ctrl

// *** testbench/fspc_flash_model.sv ***
/*
  Flash array model for the self-programming controller.
  Assumes strobes and address from the controller on core_clk_i.
*/
`timescale 1ns/1ps
module fspc_flash_model #(
  parameter logic [7:0] PROT_VAL = 8'hFF
) (
  input  wire logic        core_clk_i,
  input  wire logic        rd_en_i,
  input  wire logic        wr_en_i,
  input  wire logic        erase_en_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] mem [0:65535];
  initial begin
    foreach (mem[i])
      mem[i] = 8'hFF;
    mem[16'h0081] = PROT_VAL;
  end
  // Unselected reads show no stale byte
  assign rdata_o = rd_en_i ? mem[addr_i] : ~mem[addr_i];
  // programming only clears bits, erase fills the block
  always @(posedge core_clk_i) begin
    if (wr_en_i)
      mem[addr_i] <= mem[addr_i] & wdata_i;
    if (erase_en_i)
      for (int i = 0; i < 256; i++)
        mem[{addr_i[15:8], 8'(i)}] <= 8'hFF;
  end
endmodule // fspc_flash_model

// *** testbench/fspc_ctrl_asserts.sv ***
/*
  Port assertions for the flash self-programming controller.
  Assumes one clock domain with an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module fspc_ctrl_asserts
  import fspc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        halt_req_i,
  input wire logic        halt_o,
  input wire logic        irq_block_o,
  input wire logic        ram_block_o,
  input wire logic        fl_rd_en_o,
  input wire logic        fl_wr_en_o,
  input wire logic        fl_erase_en_o,
  input wire logic [15:0] fl_addr_o,
  input wire logic [7:0]  fl_wdata_o,
  input wire logic [7:0]  fl_rdata_i
);
  int halt_cnt_q;
  // Cycles spent in HALT so far
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_cnt_q <= 0;
    end else if (clk_en_i) begin
      halt_cnt_q <= halt_o ? halt_cnt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ram_follow_a: assert property (ram_block_o == halt_o) else $error("ram block differs from halt");
  normal_halt_a: assert property (!irq_block_o |-> !halt_o) else $error("halt in normal mode");
  write_end_a: assert property (fl_wr_en_o |-> halt_o ##1 (!halt_o && !fl_wr_en_o))
    else $error("halt not released after write");
  erase_end_a: assert property (fl_erase_en_o |-> halt_o ##1 (!halt_o && !fl_erase_en_o))
    else $error("halt not released after erase");
  write_time_a: assert property (fl_wr_en_o |-> halt_cnt_q inside {[1499:1501]})
    else $error("byte write time wrong");
  erase_time_a: assert property (fl_erase_en_o |-> halt_cnt_q inside {[84999:85001]})
    else $error("erase time wrong");
  halt_bound_a: assert property (halt_cnt_q <= 85001) else $error("halt held too long");
  entry_release_a: assert property ($rose(irq_block_o) |-> ##[1:104] !halt_o)
    else $error("entry halt not released");
  mode_read_a: assert property (reg_rd_i && reg_addr_i == MODE_CTRL_OFS |->
    reg_rdata_o[7] == 1'b0 && reg_rdata_o[1] == 1'b0 && reg_rdata_o[0] == irq_block_o) else $error("mode read wrong");
  status_read_a: assert property (reg_rd_i && reg_addr_i == ERR_STATUS_OFS |-> reg_rdata_o[7:3] == 5'h00)
    else $error("status spare bits set");
endmodule // fspc_ctrl_asserts

bind fspc_ctrl fspc_ctrl_asserts fspc_ctrl_asserts_inst (.core_clk_i, .rst_n_i, .clk_en_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .halt_req_i, .halt_o, .irq_block_o, .ram_block_o, .fl_rd_en_o,
  .fl_wr_en_o, .fl_erase_en_o, .fl_addr_o, .fl_wdata_o, .fl_rdata_i);

// *** testbench/tb_fspc_ctrl.sv ***
/*
  Self-checking bench for the flash self-programming controller.
  Assumes the flash model beside it and a 10 MHz core clock.
*/
`timescale 1ns/1ps
module tb_fspc_ctrl;
  import fspc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        halt_req = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, fl_wdata, fl_rdata, hi, lo, base, dat;
  logic [15:0] fl_addr;
  logic        halt, irq_block, ram_block, fl_rd, fl_wr, fl_erase;
  int          err_count = 0;
  int          compares = 0;
  int          n;
  always #50 clk = ~clk;
  fspc_ctrl fspc_ctrl_inst (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .halt_req_i(halt_req), .halt_o(halt), .irq_block_o(irq_block), .ram_block_o(ram_block),
    .fl_rd_en_o(fl_rd), .fl_wr_en_o(fl_wr), .fl_erase_en_o(fl_erase), .fl_addr_o(fl_addr),
    .fl_wdata_o(fl_wdata), .fl_rdata_i(fl_rdata));
  fspc_flash_model fspc_flash_model_inst (.core_clk_i(clk), .rd_en_i(fl_rd), .wr_en_i(fl_wr),
    .erase_en_i(fl_erase), .addr_i(fl_addr), .wdata_i(fl_wdata), .rdata_o(fl_rdata));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic chk_n(string what, int lo_lim, int hi_lim, int got);
    compares++;
    if (got < lo_lim || got > hi_lim) begin
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo_lim, hi_lim, got);
      err_count++;
    end
  endtask
  // Expected busy cycles: microseconds times ten at 10 MHz
  function automatic int op_cycles(logic [7:0] cmd, int nbytes);
    case (cmd)
      8'h02: return 27 * 10 * nbytes;
      8'h03: return 8500 * 10;
      8'h04: return 480 * 10;
      default: return 150 * 10;
    endcase
  endfunction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(negedge clk);
    chk(what, exp, reg_rdata);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic unlock(logic [7:0] v);
    wr(UNLOCK_CMD_OFS, UNLOCK_KEY);
    wr(MODE_CTRL_OFS, v);
    wr(MODE_CTRL_OFS, ~v);
    wr(MODE_CTRL_OFS, v);
  endtask
  task automatic wait_low(int lim, output int cyc);
    cyc = 0;
    @(negedge clk);
    while (halt === 1'b1) begin
      cyc++;
      if (cyc > lim) begin
        $display("MISMATCH halt release expected low seen high");
        err_count++;
        end_of_test();
      end
      @(negedge clk);
    end
  endtask
  task automatic run(logic [7:0] cmd, int lim, output int cyc);
    wr(PROG_CMD_OFS, cmd);
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wait_low(lim, cyc);
  endtask
  initial begin
    void'($urandom(57023));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(MODE_CTRL_OFS, 8'h7C, "mode reset");
    rd(ERR_STATUS_OFS, 8'h00, "status reset");
    run(8'h05, 4, n);
    chk_n("normal halt", 0, 0, n);
    $display("test reset and standby done");
    wr(UNLOCK_CMD_OFS, UNLOCK_KEY);
    wr(MODE_CTRL_OFS, 8'h01);
    wr(PROG_CMD_OFS, 8'h00);
    rd(ERR_STATUS_OFS, 8'h01, "stray store");
    wr(ERR_STATUS_OFS, 8'h00);
    wr(UNLOCK_CMD_OFS, UNLOCK_KEY);
    wr(MODE_CTRL_OFS, 8'h01);
    wr(MODE_CTRL_OFS, 8'h01);
    rd(ERR_STATUS_OFS, 8'h01, "bad inverse");
    rd(MODE_CTRL_OFS, 8'h7C, "mode kept");
    wr(ERR_STATUS_OFS, 8'h00);
    rd(ERR_STATUS_OFS, 8'h00, "error cleared");
    $display("test broken unlock done");
    wr(PROG_CMD_OFS, 8'h00);
    unlock(8'h01);
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wait_low(200, n);
    chk_n("entry release", 0, 104, n);
    rd(MODE_CTRL_OFS, 8'h7D, "mode self");
    chk("irq block", 8'h01, {7'h00, irq_block});
    repeat (80) @(posedge clk);
    $display("test entry done");
    hi = 8'h01 + 8'($urandom_range(30));
    base = 8'($urandom_range(200));
    lo = base;
    wr(ADDR_PTR_HI_OFS, hi);
    for (int k = 0; k < 3; k++) begin
      dat = 8'($urandom) & 8'h7F;
      wr(ADDR_PTR_LO_OFS, lo);
      wr(WRITE_BUF_OFS, dat);
      run(8'h05, 1600, n);
      chk_n("write time", op_cycles(8'h05, 1) - 2, op_cycles(8'h05, 1) + 2, n);
      chk("flash byte", dat, fspc_flash_model_inst.mem[{hi, lo}]);
      lo = lo + 8'h01;
    end
    rd(ERR_STATUS_OFS, 8'h00, "write clean");
    wr(ADDR_PTR_LO_OFS, lo - 8'h01);
    wr(WRITE_BUF_OFS, 8'h80);
    run(8'h05, 1600, n);
    rd(ERR_STATUS_OFS, 8'h04, "unerased bit");
    wr(ERR_STATUS_OFS, 8'h00);
    $display("test byte write done");
    run(8'h04, 5000, n);
    chk_n("blank time", op_cycles(8'h04, 1) - 2, op_cycles(8'h04, 1) + 2, n);
    rd(ERR_STATUS_OFS, 8'h02, "blank fail");
    wr(ERR_STATUS_OFS, 8'h00);
    run(8'h03, 86000, n);
    chk_n("erase time", op_cycles(8'h03, 1) - 2, op_cycles(8'h03, 1) + 2, n);
    for (int i = 0; i < 256; i++)
      chk("erased byte", 8'hFF, fspc_flash_model_inst.mem[{hi, 8'(i)}]);
    $display("test blank and erase done");
    wr(ADDR_PTR_LO_OFS, base);
    wr(ADDR_CMP_HI_OFS, hi);
    wr(ADDR_CMP_LO_OFS, base + 8'h03);
    // verify compares against the buffer; the block is blank now
    wr(WRITE_BUF_OFS, BLANK_BYTE);
    run(8'h02, 1200, n);
    chk_n("verify2 time", op_cycles(8'h02, 4) - 2, op_cycles(8'h02, 4) + 2, n);
    rd(ADDR_PTR_LO_OFS, base + 8'h03, "pointer end");
    rd(ERR_STATUS_OFS, 8'h00, "verify clean");
    $display("test verify done");
    wr(PROG_CMD_OFS, 8'h00);
    unlock(8'h00);
    rd(MODE_CTRL_OFS, 8'h7C, "mode normal");
    chk("irq release", 8'h00, {7'h00, irq_block});
    $display("test exit done");
    end_of_test();
  end
endmodule // tb_fspc_ctrl
